/* dv/ltrs_far_unit.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Peer unit: one packet every 16 cycles, framing chosen by the bench.
// ----
module ltrs_far_unit (
  input  wire logic clock_i,        // System clock.
  input  wire logic rst_i,          // Reset, active high.
  input  wire logic framed_en_i,    // Send valid framing.
  input  wire logic line_tx_bit_i,  // Raw bit from the local unit.
  output logic      fr_rx_valid_o,  // Packet boundary pulse.
  output logic      fr_rx_framed_o, // Framing qualifier.
  output logic      fr_rx_data_o,   // Deframed data.
  output logic      line_rx_bit_o,  // Raw bit returned.
  output logic      line_bit_en_o   // Bit strobe.
);
  logic [3:0] pkt_cnt;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pkt_cnt <= 4'h0;
    else
      pkt_cnt <= pkt_cnt + 4'h1;
  end
  // The qualifier toggles between packets so it never reads as a stale level.
  always_ff @(posedge clock_i)
  begin
    fr_rx_valid_o  <= !rst_i && (pkt_cnt == 4'hF);
    fr_rx_framed_o <= (pkt_cnt == 4'hF) ? framed_en_i : pkt_cnt[0];
    fr_rx_data_o   <= pkt_cnt[3];
    line_bit_en_o  <= pkt_cnt[0];
    line_rx_bit_o  <= line_tx_bit_i;
  end
endmodule
`default_nettype wire

/* dv/ltrs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker for the link supervisor.
// ----
module ltrs_monitor (
  input wire logic clock_i,          // System clock.
  input wire logic rst_i,            // Reset, active high.
  input wire logic fr_rx_valid_i,    // Packet boundary.
  input wire logic fr_rx_framed_i,   // Packet framing qualifier.
  input wire logic dte_dtr_i,        // Terminal ready.
  input wire logic dte_txd_i,        // Terminal transmit data.
  input wire logic rmm_packet_i,     // Management packet pulse.
  input wire logic dte_cts_o,        // Clear to send.
  input wire logic dte_cd_o,         // Carrier detect.
  input wire logic lamp_no_signal_o, // No-signal lamp.
  input wire logic lamp_dtr_o,       // Terminal ready lamp.
  input wire logic lamp_td_green_o,  // Transmit lamp green.
  input wire logic lamp_test_mode_o, // Test-mode lamp.
  input wire logic link_restart_o,   // Restart pulse.
  input wire logic line_tx_raw_o     // Pattern bypasses framer.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  link_pair_a: assert property (dte_cts_o == dte_cd_o)
    else $error("cts and cd differ");
  framed_up_a: assert property (fr_rx_valid_i && fr_rx_framed_i |-> ##[1:2] dte_cts_o)
    else $error("framed packet did not raise cts");
  unframed_down_a: assert property (fr_rx_valid_i && !fr_rx_framed_i |-> ##[1:2] !dte_cd_o)
    else $error("unframed packet left cd up");
  no_signal_a: assert property (lamp_no_signal_o == !dte_cts_o)
    else $error("no-signal lamp disagrees with link");
  dtr_lamp_a: assert property (dte_dtr_i [*3] |-> lamp_dtr_o)
    else $error("ready lamp dark");
  td_lamp_a: assert property ((!dte_txd_i) [*3] |-> lamp_td_green_o)
    else $error("transmit lamp not green on zero");
  mgmt_lamp_a: assert property (rmm_packet_i |-> ##[1:3] lamp_test_mode_o [*8])
    else $error("management pulse missing");
  restart_pulse_a: assert property (link_restart_o |=> !link_restart_o)
    else $error("restart longer than one cycle");
  restart_cause_a: assert property (link_restart_o |-> !dte_cts_o)
    else $error("restart while linked");
  cover property (link_restart_o);
  cover property ($fell(line_tx_raw_o));
  cover property ($rose(dte_cts_o));
endmodule
bind ltrs_top ltrs_monitor u_mon (.*);
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock_i, rst_i, avs_read_i, avs_write_i, sw_local_loop_i, sw_remote_loop_i, sw_pattern_i;
  logic dte_local_loop_i, dte_remote_loop_i, dte_txd_i, dte_dtr_i, fr_rx_crc_err_i, far_rdl_active_i;
  logic rmm_packet_i, rate_bad_i, fr_rx_valid_i, fr_rx_framed_i, fr_rx_data_i, line_rx_bit_i, line_bit_en_i;
  logic avs_waitrequest_o, dte_rxd_o, dte_cts_o, dte_cd_o, fr_tx_data_o, line_tx_bit_o, line_tx_raw_o;
  logic link_restart_o, remote_loop_req_o, lamp_error_lamp_o, lamp_test_mode_o, lamp_no_signal_o;
  logic lamp_td_green_o, lamp_rd_green_o, lamp_cd_green_o, lamp_cts_green_o, lamp_dtr_o, far_framed;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  int          miscompares = 0;
  int          checks_done = 0;
  int          hits, rs_at, raw_at;
  // One tick per cycle keeps the 45 s pattern run inside the cycle budget.
  ltrs_top #(.TICK_CYC(1)) DUT (.*);
  ltrs_far_unit u_far (.clock_i(clock_i), .rst_i(rst_i), .framed_en_i(far_framed), .line_tx_bit_i(line_tx_bit_o),
    .fr_rx_valid_o(fr_rx_valid_i), .fr_rx_framed_o(fr_rx_framed_i), .fr_rx_data_o(fr_rx_data_i),
    .line_rx_bit_o(line_rx_bit_i), .line_bit_en_o(line_bit_en_i));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 40);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
    begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic watch(input int n);
    logic prev;
    prev = lamp_error_lamp_o;
    hits = 0;
    rs_at = 0;
    raw_at = 0;
    for (int k = 1; k <= n; k++)
    begin
      @(negedge clock_i);
      if (lamp_error_lamp_o === 1'b1 && prev !== 1'b1)
        hits++;
      prev = lamp_error_lamp_o;
      if (link_restart_o === 1'b1 && rs_at == 0)
        rs_at = k;
      if (line_tx_raw_o !== 1'b1 && raw_at == 0)
        raw_at = k;
    end
  endtask
  task automatic follow(input logic to_dte);
    logic [3:0] h;
    h = 4'h5;
    repeat (40)
    begin
      @(negedge clock_i);
      h = {h[2:0], fr_rx_data_i};
      if (h == 4'hF || h == 4'h0)
        chk("loop_path", {31'h0, fr_rx_data_i}, {31'h0, to_dte ? dte_rxd_o : fr_tx_data_o});
    end
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    {avs_read_i, avs_write_i, sw_local_loop_i, sw_remote_loop_i, sw_pattern_i, dte_local_loop_i} = '0;
    {dte_remote_loop_i, dte_dtr_i, fr_rx_crc_err_i, far_rdl_active_i, rmm_packet_i, far_framed} = '0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    dte_txd_i = 1'b1;
    rate_bad_i = 1'b1;
    rst_i = 1'b1;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    watch(450);
    chk("powerup", 2'h2, {lamp_no_signal_o, dte_cts_o});
    chk("rate_blink", 1'h1, hits >= 2);
    bus(0, 4'h4, 32'h0);
    chk("stat_rate", 1'h1, q[0]);
    $display("power-up test done");
    @(posedge clock_i);
    rate_bad_i <= 1'b0;
    far_framed <= 1'b1;
    dte_dtr_i <= 1'b1;
    dte_txd_i <= 1'b0;
    watch(64);
    chk("lamps", 7'h6F, {dte_cts_o, dte_cd_o, lamp_no_signal_o, lamp_cd_green_o, lamp_cts_green_o,
        lamp_dtr_o, lamp_td_green_o});
    bus(0, 4'h4, 32'h0);
    chk("stat_link", 2'h3, q[2:1]);
    @(posedge clock_i);
    rmm_packet_i <= 1'b1;
    @(posedge clock_i);
    rmm_packet_i <= 1'b0;
    watch(200);
    chk("tm_pulse", 1'h1, lamp_test_mode_o);
    watch(250);
    chk("tm_end", 1'h0, lamp_test_mode_o);
    bus(1, 4'h8, 32'h0);
    @(posedge clock_i);
    fr_rx_crc_err_i <= 1'b1;
    @(posedge clock_i);
    fr_rx_crc_err_i <= 1'b0;
    watch(80);
    chk("crc_flash", 3'h2, {hits[1:0], lamp_error_lamp_o});
    bus(0, 4'h8, 32'h0);
    chk("err_count", 32'h1, q);
    bus(0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("lamp tests done");
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h0, 32'h0);
    chk("ctrl_loop", 2'h3, {q[0], lamp_test_mode_o});
    follow(1'b0);
    bus(1, 4'h0, 32'h0);
    @(posedge clock_i);
    sw_remote_loop_i <= 1'b1;
    watch(8);
    chk("rloop", 3'h6, {remote_loop_req_o, lamp_test_mode_o, fr_tx_data_o});
    @(posedge clock_i);
    far_rdl_active_i <= 1'b1;
    follow(1'b0);
    follow(1'b1);
    @(posedge clock_i);
    sw_remote_loop_i <= 1'b0;
    far_rdl_active_i <= 1'b1;
    far_framed <= 1'b0;
    watch(5000);
    chk("far_rdl_hold", 32'h0, rs_at);
    @(posedge clock_i);
    far_rdl_active_i <= 1'b0;
    far_framed <= 1'b1;
    watch(64);
    $display("loop tests done");
    @(posedge clock_i);
    far_framed <= 1'b0;
    watch(3000);
    chk("no_early_restart", 32'h0, rs_at);
    @(posedge clock_i);
    far_framed <= 1'b1;
    watch(16);
    @(posedge clock_i);
    far_framed <= 1'b0;
    watch(4200);
    chk("restart_at", 1'h1, rs_at > 3950 && rs_at < 4050);
    bus(0, 4'h4, 32'h0);
    chk("stat_startup", 2'h0, q[2:1]);
    @(posedge clock_i);
    dte_local_loop_i <= 1'b1;
    watch(8);
    chk("ll_rxd0", 2'h1, {dte_rxd_o, lamp_rd_green_o});
    @(posedge clock_i);
    dte_txd_i <= 1'b1;
    watch(8);
    chk("ll_rxd1", 2'h2, {dte_rxd_o, lamp_rd_green_o});
    @(posedge clock_i);
    dte_local_loop_i <= 1'b0;
    far_framed <= 1'b1;
    watch(64);
    $display("restart tests done");
    @(posedge clock_i);
    sw_pattern_i <= 1'b1;
    watch(20);
    chk("pat_raw", 1'h1, line_tx_raw_o);
    watch(40);
    bus(1, 4'h8, 32'h0);
    watch(100);
    bus(0, 4'h8, 32'h0);
    chk("pat_clean", 32'h0, q);
    @(posedge clock_i);
    sw_pattern_i <= 1'b0;
    @(posedge clock_i);
    sw_pattern_i <= 1'b1;
    watch(20);
    @(posedge clock_i);
    far_framed <= 1'b0;
    watch(44950);
    chk("pat_hold", 2'h3, {rs_at == 0, line_tx_raw_o});
    watch(200);
    chk("pat_stop", 1'h1, raw_at > 10 && raw_at < 120 && rs_at == 0);
    @(posedge clock_i);
    far_framed <= 1'b1;
    watch(1100);
    chk("to_blink", 1'h1, hits >= 2);
    bus(0, 4'h4, 32'h0);
    chk("stat_timeout", 1'h1, q[4]);
    @(posedge clock_i);
    sw_pattern_i <= 1'b0;
    watch(600);
    watch(300);
    chk("blink_off", 2'h0, {hits != 0, lamp_error_lamp_o});
    $display("pattern tests done");
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/ltrs_cfg.svh */
`ifndef LTRS_CFG_SVH
`define LTRS_CFG_SVH
`define LTRS_CLK_HZ           100000000
`define LTRS_STARTUP_S        50
`define LTRS_DATA_S           4
`define LTRS_TEST_S           60
`define LTRS_PAT_TIMEOUT_S    45
`define LTRS_RATE_BLINK_MS    200
`define LTRS_RMM_PULSE_MS     400
`define LTRS_FLASH_MS         50
`define LTRS_BLINK_MS         250
`define LTRS_TICK_CYC         (`LTRS_CLK_HZ / 1000)
`define LTRS_PRBS_TAP_HI      8
`define LTRS_PRBS_TAP_LO      4
`define LTRS_PRBS_SEED        9'h1FF
`define LTRS_ADDR_CTRL        4'h0
`define LTRS_ADDR_STAT        4'h4
`define LTRS_ADDR_ERRS        4'h8
`define LTRS_CTRL_RESET       8'h00
`endif

/* verilog/ltrs_pkg.sv */
package ltrs_pkg;
  typedef enum logic [1:0] {ltrs_startup, ltrs_data} ltrs_link_t;
endpackage

/* verilog/ltrs_top.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ltrs_cfg.svh"

// Overview of operation
// - Framed reception drives clear-to-send and carrier-detect
// - Send framed packets, expect framed packets back
// - Data mode restarts after four seconds unframed
// - Startup fifty seconds, pattern or far-end loop sixty seconds
// - Generator on: sixty second threshold, stop 45
// - Remote loop far end uses sixty seconds
// - Pattern switched off after forty-five seconds
// - Error lamp blinks after timeout until switch off
// - Error lamp flashes per bit error, or per frame error while no pattern runs
// - Unsupported rate at power-up blinks every 200ms
// - Management packet pulses test lamp 400ms
// - Test lamp lit in any test mode
// - No-signal lamp lit while unlinked
// - Data lamps show level of data signals
// - Carrier and clear-to-send lamps show state
// - Terminal ready lamp follows DTR
// - Local loop to terminal, remote loop to line
// - Unframed 511 pattern sent after framer
// - Tests start from switches or terminal signals
// - Linked local loop also loops far data
module ltrs_top
  import ltrs_pkg::*;
#(
  parameter int unsigned TICK_CYC = `LTRS_TICK_CYC
)(
  input  wire logic        clock_i,          // System clock, 100 MHz.
  input  wire logic        rst_i,            // Synchronous reset, active high.
  input  wire logic        avs_read_i,       // Avalon read.
  input  wire logic        avs_write_i,      // Avalon write.
  input  wire logic [3:0]  avs_address_i,    // Avalon byte address.
  input  wire logic [31:0] avs_writedata_i,  // Avalon write data.
  output logic [31:0]      avs_readdata_o,   // Avalon read data.
  output logic             avs_waitrequest_o,// Avalon wait request.
  input  wire logic        sw_local_loop_i,  // Front-panel local loop switch.
  input  wire logic        sw_remote_loop_i, // Front-panel remote loop switch.
  input  wire logic        sw_pattern_i,     // Front-panel pattern switch.
  input  wire logic        dte_local_loop_i, // Terminal local loop request.
  input  wire logic        dte_remote_loop_i,// Terminal remote loop request.
  input  wire logic        dte_txd_i,        // Terminal transmit data.
  input  wire logic        dte_dtr_i,        // Terminal ready.
  output logic             dte_rxd_o,        // Data toward terminal.
  output logic             dte_cts_o,        // Clear to send.
  output logic             dte_cd_o,         // Carrier detect.
  input  wire logic        fr_rx_valid_i,    // Packet boundary from framer.
  input  wire logic        fr_rx_framed_i,   // Packet had valid framing.
  input  wire logic        fr_rx_crc_err_i,  // Frame check error pulse.
  input  wire logic        fr_rx_data_i,     // Deframed line data.
  input  wire logic        line_rx_bit_i,    // Raw line bit for pattern check.
  input  wire logic        line_bit_en_i,    // Line bit strobe.
  input  wire logic        far_rdl_active_i, // This unit is far end of a remote loop.
  input  wire logic        rmm_packet_i,     // Valid management packet pulse.
  input  wire logic        rate_bad_i,       // Terminal rate unsupported.
  output logic             fr_tx_data_o,     // Data to framer.
  output logic             line_tx_bit_o,    // Bit onto line.
  output logic             line_tx_raw_o,    // Line bit bypasses framer.
  output logic             link_restart_o,   // Restart pulse.
  output logic             remote_loop_req_o,// Remote loop requested.
  output logic             lamp_error_lamp_o,// Error lamp.
  output logic             lamp_test_mode_o, // Test-mode lamp.
  output logic             lamp_no_signal_o, // No-signal lamp.
  output logic             lamp_td_green_o,  // Transmit lamp green.
  output logic             lamp_rd_green_o,  // Receive lamp green.
  output logic             lamp_cd_green_o,  // Carrier lamp green.
  output logic             lamp_cts_green_o, // Clear-to-send lamp green.
  output logic             lamp_dtr_o        // Terminal ready lamp.
);

  localparam logic [31:0] MS_PER_S = 32'd1000;
  localparam logic [31:0] DATA_MS  = `LTRS_DATA_S * MS_PER_S;
  localparam logic [31:0] START_MS = `LTRS_STARTUP_S * MS_PER_S;
  localparam logic [31:0] TEST_MS  = `LTRS_TEST_S * MS_PER_S;
  localparam logic [31:0] PAT_MS   = `LTRS_PAT_TIMEOUT_S * MS_PER_S;

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge clock_i)
  begin
    if (rst_i || tick_cnt == TICK_CYC - 1)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 32'd1;
  end

  assign tick = (tick_cnt == TICK_CYC - 1);

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [15:0] err_count;
  logic        rd_pend;
  logic        wr_pend;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rd_pend           <= 1'b0;
      wr_pend           <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      rd_pend           <= avs_read_i && !rd_pend;
      wr_pend           <= avs_write_i && !wr_pend;
      // Wait request is the registered inverse of the next pend state.
      avs_waitrequest_o <= !((avs_read_i && !rd_pend) || (avs_write_i && !wr_pend));
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ctrl <= `LTRS_CTRL_RESET;
    else if (wr_pend && avs_address_i == `LTRS_ADDR_CTRL)
      ctrl <= avs_writedata_i[7:0];
  end

  // ---------------------------------------------------------------
  // Test requests
  // ---------------------------------------------------------------
  ltrs_link_t  link_state;
  logic        linked;
  logic        local_loop;
  logic        remote_loop;
  logic        pat_req;
  logic        pat_run;
  logic        pat_timed_out;

  // Front panel or software start each test; terminal control lines start the two loops only.
  assign local_loop  = sw_local_loop_i || dte_local_loop_i || ctrl[0];
  assign remote_loop = sw_remote_loop_i || dte_remote_loop_i || ctrl[1];
  assign pat_req     = sw_pattern_i || ctrl[2];

  // ---------------------------------------------------------------
  // Restart supervisor
  // ---------------------------------------------------------------
  logic [31:0] unframed_ms;
  logic [31:0] threshold_ms;
  logic        restart;

  always_comb
  begin
    if (link_state == ltrs_startup)
      threshold_ms = START_MS;
    else if (pat_req || far_rdl_active_i)
      threshold_ms = TEST_MS;
    else
      threshold_ms = DATA_MS;
  end

  assign restart = tick && (unframed_ms + 32'd1 >= threshold_ms);

  always_ff @(posedge clock_i)
  begin
    if (rst_i || restart)
      unframed_ms <= '0;
    else if (fr_rx_valid_i && fr_rx_framed_i)
      unframed_ms <= '0;
    else if (tick)
      unframed_ms <= unframed_ms + 32'd1;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i || restart)
      link_state <= ltrs_startup;
    else if (fr_rx_valid_i && fr_rx_framed_i)
      link_state <= ltrs_data;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      link_restart_o <= 1'b0;
    else
      link_restart_o <= restart;
  end

  // Framed reception is the measure of line health.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || restart)
      linked <= 1'b0;
    else if (fr_rx_valid_i)
      linked <= fr_rx_framed_i;
  end

  // ---------------------------------------------------------------
  // Pattern generator and detector
  // ---------------------------------------------------------------
  logic [8:0]  prbs_tx;
  logic [8:0]  prbs_rx;
  logic [31:0] pat_ms;
  logic        bit_err;

  function automatic logic prbs_fb(input logic [8:0] s);
    prbs_fb = s[`LTRS_PRBS_TAP_HI] ^ s[`LTRS_PRBS_TAP_LO];
  endfunction

  // The pattern stays off after its time-out until the switch is released.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !pat_req)
    begin
      pat_ms        <= '0;
      pat_timed_out <= 1'b0;
    end
    else if (tick && !pat_timed_out)
    begin
      pat_ms <= pat_ms + 32'd1;
      if (pat_ms + 32'd1 >= PAT_MS)
        pat_timed_out <= 1'b1;
    end
  end

  // A linked local loop leaves the generator without a path.
  assign pat_run = pat_req && !pat_timed_out && !(local_loop && linked);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      prbs_tx <= `LTRS_PRBS_SEED;
    else if (line_bit_en_i && pat_run)
      prbs_tx <= {prbs_tx[7:0], prbs_fb(prbs_tx)};
  end

  // Detector self-synchronises on the received bits.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      prbs_rx <= `LTRS_PRBS_SEED;
    else if (line_bit_en_i)
      prbs_rx <= {prbs_rx[7:0], line_rx_bit_i};
  end

  assign bit_err = pat_run && line_bit_en_i && (line_rx_bit_i != prbs_fb(prbs_rx));

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      err_count <= '0;
    else if (wr_pend && avs_address_i == `LTRS_ADDR_ERRS)
      err_count <= (bit_err || fr_rx_crc_err_i) ? 16'h0001 : 16'h0000;
    else if (bit_err || fr_rx_crc_err_i)
      err_count <= err_count + 16'd1;
  end

  always_ff @(posedge clock_i)
  begin
    // Registered when the read is first seen, so it stands while wait request is low.
    if (rst_i)
      avs_readdata_o <= '0;
    else if (avs_read_i && !rd_pend)
    begin
      unique case (avs_address_i)
        `LTRS_ADDR_CTRL: avs_readdata_o <= {24'h000000, ctrl};
        `LTRS_ADDR_STAT: avs_readdata_o <= {27'h0000000, pat_timed_out, pat_run,
                                            linked, link_state == ltrs_data, rate_bad_i};
        `LTRS_ADDR_ERRS: avs_readdata_o <= {16'h0000, err_count};
        default:         avs_readdata_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Loop control and data path
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      dte_rxd_o     <= 1'b1;
      fr_tx_data_o  <= 1'b1;
      line_tx_bit_o <= 1'b1;
      line_tx_raw_o <= 1'b0;
    end
    else
    begin
      // Unlinked local loop returns terminal data; linked local loop or far-end remote loop returns line data.
      dte_rxd_o <= (local_loop && !linked) ? dte_txd_i : fr_rx_data_i;
      if (local_loop && linked)
        fr_tx_data_o <= fr_rx_data_i;
      else if (far_rdl_active_i)
        fr_tx_data_o <= fr_rx_data_i;
      else
        fr_tx_data_o <= dte_txd_i;
      line_tx_bit_o <= prbs_fb(prbs_tx);
      line_tx_raw_o <= pat_run;
    end
  end

  // ---------------------------------------------------------------
  // Lamps
  // ---------------------------------------------------------------
  logic [31:0] flash_ms;
  logic [31:0] blink_ms;
  logic        blink_ph;
  logic [31:0] rmm_ms;
  logic        power_up;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      flash_ms <= '0;
    else if (bit_err || (fr_rx_crc_err_i && !pat_run))
      flash_ms <= `LTRS_FLASH_MS;
    else if (tick && flash_ms != 0)
      flash_ms <= flash_ms - 32'd1;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      power_up <= 1'b1;
    else if (linked)
      power_up <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      blink_ms <= '0;
      blink_ph <= 1'b0;
    end
    else if (tick)
    begin
      if (blink_ms + 32'd1 >= (power_up && rate_bad_i ? `LTRS_RATE_BLINK_MS / 2 : `LTRS_BLINK_MS))
      begin
        blink_ms <= '0;
        blink_ph <= !blink_ph;
      end
      else
        blink_ms <= blink_ms + 32'd1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      rmm_ms <= '0;
    else if (rmm_packet_i)
      rmm_ms <= `LTRS_RMM_PULSE_MS;
    else if (tick && rmm_ms != 0)
      rmm_ms <= rmm_ms - 32'd1;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      lamp_error_lamp_o <= 1'b0;
      lamp_test_mode_o  <= 1'b0;
      lamp_no_signal_o  <= 1'b1;
      lamp_td_green_o   <= 1'b0;
      lamp_rd_green_o   <= 1'b0;
      lamp_cd_green_o   <= 1'b0;
      lamp_cts_green_o  <= 1'b0;
      lamp_dtr_o        <= 1'b0;
      dte_cts_o         <= 1'b0;
      dte_cd_o          <= 1'b0;
      remote_loop_req_o <= 1'b0;
    end
    else
    begin
      lamp_error_lamp_o <= (pat_timed_out && blink_ph)
                        || (power_up && rate_bad_i && blink_ph)
                        || (flash_ms != 0);
      lamp_test_mode_o  <= local_loop || remote_loop || pat_req
                        || far_rdl_active_i
                        || (rmm_ms != 0);
      lamp_no_signal_o  <= !linked;
      lamp_td_green_o   <= !dte_txd_i;
      lamp_rd_green_o   <= !dte_rxd_o;
      lamp_cd_green_o   <= linked;
      lamp_cts_green_o  <= linked;
      lamp_dtr_o        <= dte_dtr_i;
      dte_cts_o         <= linked;
      dte_cd_o          <= linked;
      remote_loop_req_o <= remote_loop;
    end
  end

endmodule
`default_nettype wire
